// ==== design/mrs_pkg.sv ====
// Constants and types for the serial register slave
package mrs_pkg;
  localparam int CLK_HZ      = 10_000_000;
  localparam int BAUD        = 9600;
  localparam int BIT_CYC     = (CLK_HZ + BAUD / 2) / BAUD;
  localparam int HALF_CYC    = BIT_CYC / 2;
  localparam int CHAR_BITS   = 10;
  localparam int GAP_TENTHS  = 35;
  localparam int GAP_CYC_DEF = (GAP_TENTHS * CHAR_BITS * BIT_CYC + 9) / 10;
  localparam int TW          = 11;
  localparam int GW          = 17;

  localparam logic [7:0] FC_READ  = 8'h03;
  localparam logic [7:0] FC_WRITE = 8'h06;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_QTY  = 8'h03;
  localparam logic [7:0] BCAST    = 8'h00;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hf7;

  localparam logic [15:0] MAX_QTY  = 16'h0004;
  localparam logic [16:0] NUM_REGS = 17'h00010;
  localparam logic [3:0]  REQ_LEN  = 4'h8;
  localparam logic [3:0]  MIN_LEN  = 4'h4;
  localparam logic [3:0]  LEN_OVF  = 4'h9;
  localparam logic [3:0]  EXC_LEN  = 4'h5;
  localparam logic [3:0]  READ_FIX = 4'h5;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;

  // Register numbers
  localparam logic [3:0] REG_SP1 = 4'h0, REG_PV = 4'h1, REG_PANEL = 4'h2, REG_MEAS = 4'h3;
  localparam logic [3:0] REG_SHOWN = 4'h4, REG_FWSCR = 4'h5, REG_SERA = 4'h6, REG_SERB = 4'h7;
  localparam logic [3:0] REG_HYS1 = 4'h8, REG_OUTPUT2_FLAG = 4'h9, REG_SP2 = 4'ha, REG_HYS2 = 4'hb;
  localparam logic [3:0] REG_OFFS = 4'hc, REG_OUT3 = 4'hd, REG_SP3 = 4'he, REG_HYS3 = 4'hf;

  // Status bit positions
  localparam int B_OUTPUT1_FLAG = 0, B_OUTPUT2_FLAG = 1, B_DP = 10, B_SIGN = 12;
  localparam int B_UNDER = 0, B_OVER = 1, B_O1ST = 8, B_DEFROST = 13;
  localparam int B_O2ST = 0, B_O3ST = 8;

  // Writable slots, also the index into the settings array; SL_NONE marks a register with no slot
  localparam logic [2:0] SL_SP1 = 3'h0, SL_SP2 = 3'h1, SL_SP3 = 3'h2, SL_HYS1 = 3'h3;
  localparam logic [2:0] SL_HYS2 = 3'h4, SL_HYS3 = 3'h5, SL_OFFS = 3'h6, SL_NONE = 3'h7;

  // Ranges in tenths of a unit
  localparam logic signed [15:0] HYS_MIN   = 16'sh0001;
  localparam logic signed [15:0] HYS_MAX   = 16'sh01f4;
  localparam logic signed [15:0] OFFS_MIN  = -16'sh0064;
  localparam logic signed [15:0] OFFS_MAX  = 16'sh0064;
  localparam logic signed [15:0] SHOWN_MIN = -16'sh00c7;
  localparam logic signed [15:0] SHOWN_MAX = 16'sh07cf;

  localparam logic [15:0] SP_RST = 16'h0000, HYS_RST = 16'h000a, OFFS_RST = 16'h0000;

  typedef logic [6:0][15:0] mrs_setting_type;
  localparam mrs_setting_type SET_RST =
    {OFFS_RST, HYS_RST, HYS_RST, HYS_RST, SP_RST, SP_RST, SP_RST};

  typedef struct packed {
    logic [15:0] temp, shown, serial_a, serial_b;
    logic [15:0] setpoint_lower_limit, setpoint_upper_limit;
    logic [7:0]  version, screen;
    logic        output1_flag, output2_flag, dec_point, sign;
    logic        underflow, overflow, output1_flag_state, defrost, output2_flag_state, out3_state;
  } mrs_plant_type;

  typedef enum logic [2:0] {ST_RX = 3'b001, ST_EVAL = 3'b010, ST_TX = 3'b100} mrs_fsm_type;
  typedef enum logic [1:0] {K_READ = 2'h0, K_ECHO = 2'h1, K_EXC = 2'h2} mrs_kind_type;

  typedef struct packed {
    mrs_fsm_type     st;
    logic            rx_busy, ferr, tx, tx_en;
    logic [3:0]      rx_bit, nb, len, idx, tx_bit;
    logic [TW-1:0]   rx_tmr, tx_tmr;
    logic [GW-1:0]   gap;
    logic [7:0]      rx_sh, code;
    logic [7:0][7:0] bytes;
    logic [15:0]     crc, tx_crc;
    logic [8:0]      tx_sh;
    mrs_kind_type    kind;
    mrs_setting_type set;
  } mrs_state_type;
endpackage : mrs_pkg

// ==== design/mrs_slave.sv ====
// Serial register slave: receiver, frame checker, register file and transmitter
`timescale 1ns/1ps
module mrs_slave
  import mrs_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC,
  parameter int GAP_CYC    = GAP_CYC_DEF
) (
  input  wire logic            i_clk_sys,
  input  wire logic            i_rstn,
  input  wire logic            i_rx,
  input  wire logic [7:0]      i_slave_addr,
  input  wire mrs_plant_type   i_plant,
  output logic                 o_tx,
  output logic                 o_tx_en,
  output mrs_setting_type      o_settings
);

  // Bit time may be shortened for quick runs; the bit timers are only TW bits wide
  if (BIT_CYCLES < 16 || BIT_CYCLES > 2 ** TW) begin : g_bit_chk
    $error("BIT_CYCLES out of range");
  end

  if (GAP_CYC < CHAR_BITS * BIT_CYCLES || GAP_CYC >= 2 ** GW) begin : g_chk
    $error("GAP_CYC out of range");
  end

  localparam int HALF_CYCLES = BIT_CYCLES / 2;

  mrs_state_type   s;
  mrs_state_type   next_s;

  logic [7:0]      addr;
  logic [7:0]      fc;
  logic [15:0]     ra;
  logic [15:0]     rv;
  logic            good;
  logic            bc;
  logic            mine;
  logic            over;
  logic [2:0]      slot;
  logic            inrng;
  logic [3:0]      pay;
  logic [3:0]      ridx;
  logic [3:0]      rreg;
  logic [15:0]     rword;
  logic [7:0]      pbyte;
  logic [7:0]      tbyte;
  logic            reply;

  // One byte folded into the running check word, low bit first
  function automatic logic [15:0] mrs_crc_step(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : mrs_crc_step

  // Writable register numbers map to settings slots; everything else is refused
  function automatic logic [2:0] mrs_slot(input logic [15:0] r);
    case (r)
      {12'h000, REG_SP1}:  return SL_SP1;
      {12'h000, REG_SP2}:  return SL_SP2;
      {12'h000, REG_SP3}:  return SL_SP3;
      {12'h000, REG_HYS1}: return SL_HYS1;
      {12'h000, REG_HYS2}: return SL_HYS2;
      {12'h000, REG_HYS3}: return SL_HYS3;
      {12'h000, REG_OFFS}: return SL_OFFS;
      default:             return SL_NONE;
    endcase
  endfunction : mrs_slot

  // Request decode shared by evaluation and reply
  always_comb begin
    addr  = s.bytes[0];
    fc    = s.bytes[1];
    ra    = {s.bytes[2], s.bytes[3]};
    rv    = {s.bytes[4], s.bytes[5]};
    good  = s.nb >= MIN_LEN && s.nb <= REQ_LEN && s.crc == 16'h0000 && !s.ferr;
    bc    = addr == BCAST;
    mine  = addr == i_slave_addr && i_slave_addr >= ADDR_MIN
            && i_slave_addr <= ADDR_MAX;
    over  = ({1'b0, ra} + {1'b0, rv}) > NUM_REGS;
    slot  = mrs_slot(ra);
    case (slot)
      SL_SP1, SL_SP2, SL_SP3: begin
        inrng = $signed(rv) >= $signed(i_plant.setpoint_lower_limit)
                && $signed(rv) <= $signed(i_plant.setpoint_upper_limit);
      end
      SL_OFFS: begin
        inrng = $signed(rv) >= OFFS_MIN && $signed(rv) <= OFFS_MAX;
      end
      default: begin
        inrng = $signed(rv) >= HYS_MIN && $signed(rv) <= HYS_MAX;
      end
    endcase
  end

  // Register read mux; words are taken per byte so a live input may tear
  always_comb begin
    pay   = 4'(s.len - 4'h2);
    ridx  = 4'(s.idx - 4'h3);
    rreg  = 4'(ra[3:0] + {1'b0, ridx[3:1]});
    rword = 16'h0000;
    case (rreg)
      REG_SP1:   rword = s.set[SL_SP1];
      REG_PV:    rword = i_plant.temp;
      REG_PANEL: begin
        rword[B_OUTPUT1_FLAG] = i_plant.output1_flag;
        rword[B_OUTPUT2_FLAG] = i_plant.output2_flag;
        rword[B_DP]   = i_plant.dec_point;
        rword[B_SIGN] = i_plant.sign;
      end
      REG_MEAS:  begin
        rword[B_UNDER]   = i_plant.underflow;
        rword[B_OVER]    = i_plant.overflow;
        rword[B_O1ST]    = i_plant.output1_flag_state;
        rword[B_DEFROST] = i_plant.defrost;
      end
      REG_SHOWN: begin
        if ($signed(i_plant.shown) < SHOWN_MIN) rword = SHOWN_MIN;
        else if ($signed(i_plant.shown) > SHOWN_MAX) rword = SHOWN_MAX;
        else rword = i_plant.shown;
      end
      REG_FWSCR: rword = {i_plant.version, i_plant.screen};
      REG_SERA:  rword = i_plant.serial_a;
      REG_SERB:  rword = i_plant.serial_b;
      REG_HYS1:  rword = s.set[SL_HYS1];
      REG_OUTPUT2_FLAG:  rword[B_O2ST] = i_plant.output2_flag_state;
      REG_SP2:   rword = s.set[SL_SP2];
      REG_HYS2:  rword = s.set[SL_HYS2];
      REG_OFFS:  rword = s.set[SL_OFFS];
      REG_OUT3:  rword[B_O3ST] = i_plant.out3_state;
      REG_SP3:   rword = s.set[SL_SP3];
      default:   rword = s.set[SL_HYS3];
    endcase
    case (s.kind)
      K_READ: begin
        if (s.idx == 4'h0) pbyte = addr;
        else if (s.idx == 4'h1) pbyte = fc;
        else if (s.idx == 4'h2) pbyte = {rv[6:0], 1'b0};
        else pbyte = ridx[0] ? rword[7:0] : rword[15:8];
      end
      K_EXC: begin
        if (s.idx == 4'h0) pbyte = addr;
        else if (s.idx == 4'h1) pbyte = fc | EXC_FLAG;
        else pbyte = s.code;
      end
      default: pbyte = s.bytes[s.idx[2:0]];
    endcase
    if (s.idx == pay) tbyte = s.tx_crc[7:0];
    else if (s.idx == 4'(pay + 4'h1)) tbyte = s.tx_crc[15:8];
    else tbyte = pbyte;
  end

  always_comb begin
    next_s = s;
    reply  = 1'b0;
    case (s.st)
      ST_RX: begin
        next_s.tx_en = 1'b0;
        next_s.tx    = 1'b1;
        if (s.rx_busy) begin
          next_s.gap = '0;
          if (s.rx_tmr != '0) begin
            next_s.rx_tmr = s.rx_tmr - 1'b1;
          end else begin
            next_s.rx_tmr = TW'(BIT_CYCLES - 1);
            next_s.rx_bit = 4'(s.rx_bit + 4'h1);
            if (s.rx_bit == 4'h0) begin
              if (i_rx) next_s.rx_busy = 1'b0;
            end else if (s.rx_bit < 4'h9) begin
              next_s.rx_sh = {i_rx, s.rx_sh[7:1]};
            end else begin
              next_s.rx_busy = 1'b0;
              if (!i_rx) next_s.ferr = 1'b1;
              if (s.nb < REQ_LEN) next_s.bytes[s.nb[2:0]] = s.rx_sh;
              if (s.nb != LEN_OVF) next_s.nb = 4'(s.nb + 4'h1);
              next_s.crc = mrs_crc_step(s.crc, s.rx_sh);
            end
          end
        end else if (!i_rx) begin
          next_s.rx_busy = 1'b1;
          next_s.rx_bit  = 4'h0;
          next_s.rx_tmr  = TW'(HALF_CYCLES - 1);
          next_s.gap     = '0;
        end else if (s.gap != GW'(GAP_CYC)) begin
          next_s.gap = s.gap + 1'b1;
        end else if (s.nb != 4'h0) begin
          next_s.st = ST_EVAL;
        end
      end
      ST_EVAL: begin
        next_s.st     = ST_RX;
        next_s.nb     = 4'h0;
        next_s.crc    = CRC_INIT;
        next_s.tx_crc = CRC_INIT;
        next_s.ferr   = 1'b0;
        next_s.gap    = '0;
        next_s.idx    = 4'h0;
        next_s.kind   = K_EXC;
        next_s.len    = EXC_LEN;
        if (good && (bc || mine)) begin
          if (fc != FC_READ && fc != FC_WRITE) begin
            next_s.code = EXC_FUNC;
            reply       = !bc;
          end else if (s.nb != REQ_LEN) begin
            reply = 1'b0;
          end else if (fc == FC_READ) begin
            reply = !bc;
            if (rv == 16'h0000 || rv > MAX_QTY) begin
              next_s.code = EXC_QTY;
            end else if (over) begin
              next_s.code = EXC_ADDR;
            end else begin
              next_s.kind = K_READ;
              next_s.len  = 4'(READ_FIX + {rv[2:0], 1'b0});
            end
          end else begin
            reply = !bc;
            if (slot == SL_NONE) begin
              next_s.code = EXC_ADDR;
            end else if (!inrng) begin
              next_s.code = EXC_QTY;
            end else begin
              next_s.set[slot] = rv;
              next_s.kind      = K_ECHO;
              next_s.len       = REQ_LEN;
            end
          end
        end
        if (reply) begin
          next_s.st    = ST_TX;
          next_s.tx_en = 1'b1;
        end
      end
      ST_TX: begin
        if (s.tx_tmr != '0) begin
          next_s.tx_tmr = s.tx_tmr - 1'b1;
        end else if (s.tx_bit != 4'h0) begin
          next_s.tx     = s.tx_sh[0];
          next_s.tx_sh  = {1'b1, s.tx_sh[8:1]};
          next_s.tx_bit = 4'(s.tx_bit - 4'h1);
          next_s.tx_tmr = TW'(BIT_CYCLES - 1);
        end else if (s.idx != s.len) begin
          next_s.tx     = 1'b0;
          next_s.tx_sh  = {1'b1, tbyte};
          next_s.tx_bit = 4'h9;
          next_s.tx_tmr = TW'(BIT_CYCLES - 1);
          next_s.idx    = 4'(s.idx + 4'h1);
          if (s.idx < pay) next_s.tx_crc = mrs_crc_step(s.tx_crc, tbyte);
        end else begin
          next_s.st    = ST_RX;
          next_s.tx_en = 1'b0;
          next_s.tx    = 1'b1;
        end
      end
      default: next_s.st = ST_RX;
    endcase
  end

  // Reset drives the line to idle mark with the driver off
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s     <= '0;
      s.st  <= ST_RX;
      s.crc <= CRC_INIT;
      s.tx  <= 1'b1;
      s.set <= SET_RST;
    end else begin
      s <= next_s;
    end
  end

  assign o_tx       = s.tx;
  assign o_tx_en    = s.tx_en;
  assign o_settings = s.set;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  a_tx_idle_mark: assert property (!o_tx_en |-> o_tx)
    else $error("line not idle while driver off");
  a_start_bit_len: assert property ($fell(o_tx) |=> !o_tx [*8])
    else $error("start bit too short");
  a_crc_silent: assert property ((s.st == ST_EVAL && s.crc != 16'h0000)
    |=> s.st == ST_RX && !o_tx_en)
    else $error("reply after crc failure");
  a_bcast_read_quiet: assert property ((s.st == ST_EVAL && good && bc && fc == FC_READ)
    |=> s.st == ST_RX && !o_tx_en)
    else $error("broadcast read answered");
  a_qty_limit: assert property ((s.st == ST_EVAL && good && mine && fc == FC_READ
    && s.nb == REQ_LEN && rv > MAX_QTY) |=> s.kind == K_EXC && s.code == EXC_QTY)
    else $error("oversized read not refused");
  a_ro_write_kept: assert property ((s.st == ST_EVAL && fc == FC_WRITE
    && slot == SL_NONE) |=> o_settings == $past(o_settings))
    else $error("read-only write changed a register");
  a_exc_header: assert property ((s.st == ST_TX && s.kind == K_EXC && s.idx == 4'h1
    && s.tx_bit == 4'h0 && s.tx_tmr == '0) |-> tbyte == (fc | EXC_FLAG))
    else $error("exception function byte wrong");
  a_hys_range: assert property ($signed(o_settings[SL_HYS1]) >= HYS_MIN
    && $signed(o_settings[SL_HYS1]) <= HYS_MAX)
    else $error("hysteresis out of range");
  a_offs_range: assert property ($signed(o_settings[SL_OFFS]) >= OFFS_MIN
    && $signed(o_settings[SL_OFFS]) <= OFFS_MAX)
    else $error("offset out of range");
  a_gap_eval: assert property ((s.st == ST_RX && !s.rx_busy && i_rx
    && s.gap == GW'(GAP_CYC) && s.nb != 4'h0) |=> s.st == ST_EVAL)
    else $error("gap did not end frame");
  a_bad_addr_quiet: assert property ((s.st == ST_EVAL && !bc && !mine)
    |=> s.st == ST_RX && !o_tx_en)
    else $error("foreign address answered");
  a_bad_func_code: assert property ((s.st == ST_EVAL && good && mine
    && fc != FC_READ && fc != FC_WRITE) |=> s.kind == K_EXC && s.code == EXC_FUNC && o_tx_en)
    else $error("unknown function not refused with code 01");
  a_range_write_kept: assert property ((s.st == ST_EVAL && fc == FC_WRITE
    && slot != SL_NONE && !inrng) |=> o_settings == $past(o_settings))
    else $error("out-of-range write changed a register");
  a_write_applied: assert property ((s.st == ST_EVAL && good && (bc || mine)
    && fc == FC_WRITE && s.nb == REQ_LEN && slot != SL_NONE && inrng)
    |=> o_settings[slot] == rv && o_tx_en == !bc)
    else $error("valid write not applied or wrongly answered");
  a_sp_limit_err: assert property ((s.st == ST_EVAL && good && mine && fc == FC_WRITE
    && s.nb == REQ_LEN && (slot == SL_SP1 || slot == SL_SP2 || slot == SL_SP3)
    && $signed(rv) > $signed(i_plant.setpoint_upper_limit))
    |=> s.kind == K_EXC && s.code == EXC_QTY)
    else $error("setpoint above upper limit accepted");
  a_read_len: assert property ((s.st == ST_EVAL && good && mine && fc == FC_READ
    && s.nb == REQ_LEN && rv != 16'h0000 && rv <= MAX_QTY && !over)
    |=> s.kind == K_READ && s.len == 4'(READ_FIX + {rv[2:0], 1'b0}) && o_tx_en)
    else $error("valid read not answered with data");
  a_reg_range_err: assert property ((s.st == ST_EVAL && good && mine && fc == FC_READ
    && s.nb == REQ_LEN && rv != 16'h0000 && rv <= MAX_QTY && over)
    |=> s.kind == K_EXC && s.code == EXC_ADDR)
    else $error("read past the map not refused with code 02");
  a_bcast_write_quiet: assert property ((s.st == ST_EVAL && bc && fc == FC_WRITE)
    |=> !o_tx_en)
    else $error("broadcast write answered");
  a_short_read_quiet: assert property ((s.st == ST_EVAL && fc == FC_READ
    && s.nb != REQ_LEN) |=> !o_tx_en)
    else $error("short read frame answered");
  a_tx_en_lead: assert property ($rose(o_tx_en) |=> !o_tx)
    else $error("start bit does not follow driver enable");
  a_tx_end_stop: assert property ($fell(o_tx_en) |-> o_tx && $past(o_tx))
    else $error("driver released before stop bit ended");
  a_shown_clamp: assert property ((s.st == ST_TX && rreg == REG_SHOWN)
    |-> $signed(rword) >= SHOWN_MIN && $signed(rword) <= SHOWN_MAX)
    else $error("shown value outside display range");

endmodule : mrs_slave

// ==== bench/mrs_master.sv ====
// Bus master model: sends request frames and collects reply bytes
`timescale 1ns/1ps
module mrs_master
  import mrs_pkg::*;
#(
  parameter int BIT = BIT_CYC,
  parameter int GAP = GAP_CYC_DEF
) (
  input  wire logic i_clk_sys,
  input  wire logic i_tx,
  input  wire logic i_tx_en,
  output logic      o_rx
);
  logic [7:0] rsp[$];
  logic       got;
  logic       frame_err;

  initial o_rx = 1'b1;

  // Own CRC, kept apart from the design's helper
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[k]) begin
      c = c ^ {8'h00, q[k]};
      for (int i = 0; i < 8; i++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction : crc16

  task automatic hold_bit(input logic b);
    o_rx = b;
    repeat (BIT) @(posedge i_clk_sys);
    #1;
  endtask : hold_bit

  // CRC goes low byte first; a bad frame flips one CRC bit
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0] ^ {7'h00, bad});
    q.push_back(c[15:8]);
    @(posedge i_clk_sys);
    #1;
    foreach (q[k]) begin
      hold_bit(1'b0);
      for (int i = 0; i < 8; i++) begin
        hold_bit(q[k][i]);
      end
      hold_bit(1'b1);
    end
  endtask : send

  // Waits past the idle gap so the frame end is seen
  task automatic recv();
    int         n;
    logic [7:0] b;
    rsp.delete();
    got = 1'b0;
    frame_err = 1'b0;
    n = 0;
    while (i_tx_en !== 1'b1 && n < GAP + 200) begin
      @(negedge i_clk_sys);
      n++;
    end
    if (i_tx_en === 1'b1) begin
      got = 1'b1;
      // Longest reply is a four-register read: 13 bytes
      for (int k = 0; k < 13; k++) begin
        n = 0;
        while (i_tx === 1'b1 && i_tx_en === 1'b1 && n < 3 * BIT) begin
          @(negedge i_clk_sys);
          n++;
        end
        if (i_tx_en !== 1'b1 || i_tx !== 1'b0) break;
        repeat (BIT / 2) @(negedge i_clk_sys);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(negedge i_clk_sys);
          b[i] = i_tx;
        end
        repeat (BIT) @(negedge i_clk_sys);
        if (i_tx !== 1'b1) frame_err = 1'b1;
        rsp.push_back(b);
      end
      // The next request must not start before the driver is released
      n = 0;
      while (i_tx_en === 1'b1 && n < 2 * BIT) begin
        @(negedge i_clk_sys);
        n++;
      end
    end
  endtask : recv
endmodule : mrs_master

// ==== bench/tb.sv ====
// Self-checking testbench for the serial register slave
`timescale 1ns/1ps
module tb;
  import mrs_pkg::*;
  // A short bit time keeps the run brief; the frame logic scales with it
  localparam int BIT = 16;
  localparam int GAP = CHAR_BITS * BIT;

  logic            clk_sys;
  logic            rstn;
  logic            rx;
  logic            tx;
  logic            tx_en;
  logic [7:0]      slave_addr;
  mrs_plant_type   plant;
  mrs_setting_type settings;
  int              fail_count;
  int              n_compared;

  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  mrs_slave #(.BIT_CYCLES(BIT), .GAP_CYC(GAP)) dut (
    .i_clk_sys   (clk_sys),
    .i_rstn      (rstn),
    .i_rx        (rx),
    .i_slave_addr(slave_addr),
    .i_plant     (plant),
    .o_tx        (tx),
    .o_tx_en     (tx_en),
    .o_settings  (settings)
  );

  mrs_master #(.BIT(BIT), .GAP(GAP)) m (
    .i_clk_sys(clk_sys),
    .i_tx     (tx),
    .i_tx_en  (tx_en),
    .o_rx     (rx)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One exchange; an empty expectation means silence is required
  task automatic run(input logic [7:0] req[$], input logic [7:0] exp[$], input logic bad);
    logic [15:0] c;
    m.send(req, bad);
    m.recv();
    check({15'h0, m.got}, {15'h0, exp.size() != 0});
    if (exp.size() != 0) begin
      c = m.crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
      check(16'(m.rsp.size()), 16'(exp.size()));
      foreach (exp[i]) begin
        if (i < m.rsp.size()) check({8'h00, m.rsp[i]}, {8'h00, exp[i]});
      end
      check({15'h0, m.frame_err}, 16'h0000);
    end
  endtask : run

  task automatic s_reads();
    run('{8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h04}, '{8'h05, 8'h03, 8'h08, 8'h00, 8'h00,
      8'h00, 8'hfa, 8'h04, 8'h01, 8'h21, 8'h02}, 1'b0);
    run('{8'h05, 8'h03, 8'h00, 8'h04, 8'h00, 8'h04}, '{8'h05, 8'h03, 8'h08, 8'h07, 8'hcf,
      8'h18, 8'h03, 8'h12, 8'h34, 8'h56, 8'h78}, 1'b0);
  endtask : s_reads

  task automatic s_read_errors();
    run('{8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h05}, '{8'h05, 8'h83, 8'h03}, 1'b0);
    run('{8'h05, 8'h03, 8'h00, 8'h0e, 8'h00, 8'h03}, '{8'h05, 8'h83, 8'h02}, 1'b0);
    run('{8'h05, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h05, 8'h84, 8'h01}, 1'b0);
  endtask : s_read_errors

  task automatic s_writes();
    run('{8'h05, 8'h06, 8'h00, 8'h0a, 8'h03, 8'he8},
      '{8'h05, 8'h06, 8'h00, 8'h0a, 8'h03, 8'he8}, 1'b0);
    check(settings[1], 16'h03e8);
    run('{8'h05, 8'h06, 8'h00, 8'h00, 8'h03, 8'he9}, '{8'h05, 8'h86, 8'h03}, 1'b0);
    check(settings[0], 16'h0000);
    run('{8'h05, 8'h06, 8'h00, 8'h01, 8'h00, 8'h01}, '{8'h05, 8'h86, 8'h02}, 1'b0);
    run('{8'h05, 8'h03, 8'h00, 8'h08, 8'h00, 8'h04}, '{8'h05, 8'h03, 8'h08, 8'h00, 8'h0a,
      8'h00, 8'h01, 8'h03, 8'he8, 8'h00, 8'h0a}, 1'b0);
  endtask : s_writes

  task automatic s_silent();
    run('{8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{}, 1'b1);
    run('{8'h06, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{}, 1'b0);
    run('{8'h05, 8'h03}, '{}, 1'b0);
    run('{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{}, 1'b0);
  endtask : s_silent

  task automatic s_bcast_write();
    run('{8'h00, 8'h06, 8'h00, 8'h0c, 8'hff, 8'h9c}, '{}, 1'b0);
    check(settings[6], 16'hff9c);
    run('{8'h05, 8'h03, 8'h00, 8'h0c, 8'h00, 8'h02},
      '{8'h05, 8'h03, 8'h04, 8'hff, 8'h9c, 8'h01, 8'h00}, 1'b0);
  endtask : s_bcast_write

  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // Fifteen exchanges of under 4k cycles each fit well inside this span
  initial begin
    repeat (80_000) @(posedge clk_sys);
    fail_count++;
    report_and_stop();
  end

  initial begin
    fail_count = 0;
    n_compared = 0;
    rstn = 1'b0;
    slave_addr = 8'h05;
    plant = '{temp: 16'h00fa, shown: 16'h07cf, serial_a: 16'h1234, serial_b: 16'h5678,
      setpoint_lower_limit: 16'h0000, setpoint_upper_limit: 16'h03e8, version: 8'h18,
      screen: 8'h03, output1_flag: 1'b1, dec_point: 1'b1, overflow: 1'b1, output1_flag_state: 1'b1,
      defrost: 1'b1, output2_flag_state: 1'b1, out3_state: 1'b1, default: '0};
    repeat (20) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    s_reads();
    s_read_errors();
    s_writes();
    s_silent();
    s_bcast_write();
    report_and_stop();
  end
endmodule : tb
